// File: nbdt_params.svh
// constants for the nibble core data transfer block
`ifndef NBDT_PARAMS_SVH
`define NBDT_PARAMS_SVH
`define NBDT_FLAG_Z 0
`define NBDT_FLAG_C 1
`define NBDT_FLAG_I 2
`define NBDT_FLAG_E 3
`define NBDT_LOW_PAGE8 8'h00
`define NBDT_HIGH_PAGE8 8'hFF
`define NBDT_LOW_PAGE6 10'h000
`define NBDT_HIGH_PAGE6 10'h3FF
`define NBDT_RST16 16'h0000
`define NBDT_RST8 8'h00
`define NBDT_RST4 4'h0
`define NBDT_ONE16 16'h0001
`define NBDT_MASK2 8'h03
`define NBDT_MASK4 8'h0F
`define NBDT_MASK6 8'h3F
`define NBDT_MASK8 8'hFF
`define NBDT_REG_A 4'h0
`define NBDT_REG_B 4'h1
`define NBDT_REG_X 4'h2
`define NBDT_REG_Y 4'h3
`define NBDT_REG_F 4'h4
`define NBDT_REG_EXT 4'h5
`define NBDT_REG_SP1 4'h6
`define NBDT_REG_SP2 4'h7
`define NBDT_REG_PC 4'h8
`endif

// File: nbdt_pkg.sv
// types for the nibble core data transfer block
package nbdt_pkg;
   typedef enum logic [3:0] {
      LOC_A = 4'h0,
      LOC_B = 4'h1,
      LOC_F = 4'h2,
      LOC_IMM = 4'h3,
      LOC_MX = 4'h4,
      LOC_MXI = 4'h5,
      LOC_MY = 4'h6,
      LOC_MYI = 4'h7,
      LOC_L6 = 4'h8,
      LOC_H6 = 4'h9,
      LOC_L8 = 4'hA,
      LOC_H8 = 4'hB
   } nbdt_loc_e;
   typedef enum logic {
      NK_MOVE = 1'b0,
      NK_BYTE = 1'b1
   } nbdt_kind_e;
   typedef enum logic [3:0] {
      BD_BA = 4'h0,
      BD_XH = 4'h1,
      BD_XL = 4'h2,
      BD_YH = 4'h3,
      BD_YL = 4'h4,
      BD_X = 4'h5,
      BD_Y = 4'h6,
      BD_EXT = 4'h7,
      BD_SP1 = 4'h8,
      BD_SP2 = 4'h9
   } nbdt_bdst_e;
   typedef enum logic [1:0] {
      IW2 = 2'h0,
      IW4 = 2'h1,
      IW6 = 2'h2,
      IW8 = 2'h3
   } nbdt_iw_e;
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_RUN1 = 2'b01,
      S_WB = 2'b11
   } nbdt_state_e;
   typedef struct packed {
      nbdt_kind_e kind;
      nbdt_loc_e dst;
      nbdt_loc_e src;
      nbdt_bdst_e bdst;
      nbdt_iw_e iw;
      logic sgn;
      logic [7:0] imm;
   } nbdt_op_s;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [3:0] wdata;
   } nbdt_mem_s;
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } nbdt_reg_req_s;
endpackage : nbdt_pkg

// File: nbdt_addr.sv
// operand address generator for indirect and absolute forms
`include "nbdt_params.svh"
module nbdt_addr (
   input nbdt_pkg::nbdt_loc_e loc,
   input wire logic [15:0] x,
   input wire logic [15:0] y,
   input wire logic [7:0] imm,
   input wire logic [7:0] ext,
   input wire logic ext_on,
   output logic [15:0] addr
);
   import nbdt_pkg::*;

   function automatic logic [15:0] page8(input logic hi, input logic [7:0] v);
      page8 = {(hi ? `NBDT_HIGH_PAGE8 : `NBDT_LOW_PAGE8), v};
   endfunction : page8

   function automatic logic [15:0] page6(input logic hi, input logic [5:0] v);
      page6 = {(hi ? `NBDT_HIGH_PAGE6 : `NBDT_LOW_PAGE6), v};
   endfunction : page6

   always_comb begin
      case (loc)
         LOC_MX: addr = ext_on ? page8(1'b0, ext) : x;
         LOC_MXI: addr = x;
         LOC_MY: addr = ext_on ? page8(1'b1, ext) : y;
         LOC_MYI: addr = y;
         LOC_L6: addr = page6(1'b0, imm[5:0]);
         LOC_H6: addr = page6(1'b1, imm[5:0]);
         LOC_L8: addr = page8(1'b0, imm);
         LOC_H8: addr = page8(1'b1, imm);
         default: addr = `NBDT_RST16;
      endcase
   end
endmodule : nbdt_addr

// File: nbdt_core.sv
// data transfer execution logic of the nibble core
//
// Overview of operation
// - two 4-bit data registers a and b also act as one byte with b as the upper nibble.
// - two 16-bit index registers x and y each have an upper and a lower byte half.
// - a 4-bit flag register holds zero, carry, interrupt and extension flags.
// - a byte move into the prefix register supplies the address byte of the next instruction.
// - both stack pointers are 16 bits; writes set bits 9..2 of the first, 7..0 of the second.
// - 8-bit absolute addresses land in 0x0000..0x00FF or 0xFF00..0xFFFF.
// - 6-bit absolute addresses land in 0x0000..0x003F or 0xFFC0..0xFFFF.
// - after a prefix load, plain x indirect uses the low page and plain y the high page.
// - post-increment forms access memory at the old index, then add one to it.
// - memory to memory moves take two bus cycles, moves with one memory operand one, register and immediate moves none.
// - moving into the flag register loads all four flags; moving out copies them.
// - immediates are unsigned 2, 4, 6 or 8 bits, plus one signed byte form.
// - the program counter is 16 bits wide.
`include "nbdt_params.svh"
module nbdt_core (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic OP_VALID,
   input nbdt_pkg::nbdt_op_s OP_IN,
   output logic OP_READY,
   output logic OP_DONE,
   output nbdt_pkg::nbdt_mem_s MEM_OUT,
   input wire logic [3:0] MEM_RDATA,
   input nbdt_pkg::nbdt_reg_req_s REG_REQ,
   output logic [15:0] REG_RDATA
);
   import nbdt_pkg::*;

   typedef struct packed {
      nbdt_state_e st;
      logic [3:0] a;
      logic [3:0] b;
      logic [3:0] f;
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] sp1;
      logic [15:0] sp2;
      logic [15:0] pc;
      logic [7:0] ext;
      nbdt_op_s op;
      logic [15:0] daddr;
      nbdt_mem_s mem;
      logic done;
      logic [15:0] rdata;
   } nbdt_core_s;

   nbdt_core_s s_r;
   nbdt_core_s s_nxt;
   logic [15:0] src_addr;
   logic [15:0] dst_addr;
   logic ext_on;

   function automatic logic is_mem(input nbdt_loc_e l);
      is_mem = (l != LOC_A) && (l != LOC_B) && (l != LOC_F) && (l != LOC_IMM);
   endfunction : is_mem

   function automatic logic [7:0] imm_val(input nbdt_iw_e iw, input logic [7:0] v);
      case (iw)
         IW2: imm_val = v & `NBDT_MASK2;
         IW4: imm_val = v & `NBDT_MASK4;
         IW6: imm_val = v & `NBDT_MASK6;
         default: imm_val = v & `NBDT_MASK8;
      endcase
   endfunction : imm_val

   function automatic logic [15:0] widen(input logic sgn, input logic [7:0] v);
      widen = sgn ? {{8{v[7]}}, v} : {8'h00, v};
   endfunction : widen

   assign ext_on = s_r.f[`NBDT_FLAG_E];

   nbdt_addr u_src_addr (
      .loc(OP_IN.src),
      .x(s_r.x),
      .y(s_r.y),
      .imm(OP_IN.imm),
      .ext(s_r.ext),
      .ext_on(ext_on),
      .addr(src_addr)
   );

   nbdt_addr u_dst_addr (
      .loc(OP_IN.dst),
      .x(s_r.x),
      .y(s_r.y),
      .imm(OP_IN.imm),
      .ext(s_r.ext),
      .ext_on(ext_on),
      .addr(dst_addr)
   );

   always_comb begin
      logic [3:0] sv;
      logic [7:0] iv;
      logic accept;
      sv = `NBDT_RST4;
      iv = imm_val(OP_IN.iw, OP_IN.imm);
      accept = OP_VALID && (s_r.st == S_IDLE);
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      s_nxt.mem.rd = 1'b0;
      s_nxt.mem.wr = 1'b0;
      case (OP_IN.src)
         LOC_A: sv = s_r.a;
         LOC_B: sv = s_r.b;
         LOC_F: sv = s_r.f;
         default: sv = iv[3:0];
      endcase
      case (s_r.st)
         S_IDLE: begin
            if (accept) begin
               s_nxt.op = OP_IN;
               s_nxt.daddr = dst_addr;
               s_nxt.pc = s_r.pc + `NBDT_ONE16;
               s_nxt.f[`NBDT_FLAG_E] = 1'b0;
               if (OP_IN.kind == NK_BYTE) begin
                  s_nxt.done = 1'b1;
                  case (OP_IN.bdst)
                     BD_BA: begin
                        s_nxt.b = OP_IN.imm[7:4];
                        s_nxt.a = OP_IN.imm[3:0];
                     end
                     BD_XH: s_nxt.x[15:8] = OP_IN.imm;
                     BD_XL: s_nxt.x[7:0] = OP_IN.imm;
                     BD_YH: s_nxt.y[15:8] = OP_IN.imm;
                     BD_YL: s_nxt.y[7:0] = OP_IN.imm;
                     BD_X: s_nxt.x = widen(OP_IN.sgn, OP_IN.imm);
                     BD_Y: s_nxt.y = widen(OP_IN.sgn, OP_IN.imm);
                     BD_EXT: begin
                        s_nxt.ext = OP_IN.imm;
                        s_nxt.f[`NBDT_FLAG_E] = 1'b1;
                     end
                     BD_SP1: s_nxt.sp1 = {6'h00, OP_IN.imm, 2'h0};
                     BD_SP2: s_nxt.sp2 = {8'h00, OP_IN.imm};
                     default: s_nxt.done = 1'b1;
                  endcase
               end else begin
                  if (is_mem(OP_IN.src)) begin
                     s_nxt.mem.rd = 1'b1;
                     s_nxt.mem.addr = src_addr;
                     s_nxt.st = S_RUN1;
                  end else if (is_mem(OP_IN.dst)) begin
                     s_nxt.mem.wr = 1'b1;
                     s_nxt.mem.addr = dst_addr;
                     s_nxt.mem.wdata = sv;
                     s_nxt.done = 1'b1;
                  end else begin
                     s_nxt.done = 1'b1;
                     case (OP_IN.dst)
                        LOC_A: s_nxt.a = sv;
                        LOC_B: s_nxt.b = sv;
                        LOC_F: s_nxt.f = sv;
                        default: s_nxt.done = 1'b1;
                     endcase
                  end
                  // index advances after its address was captured above
                  if ((OP_IN.src == LOC_MXI) || (OP_IN.dst == LOC_MXI)) begin
                     s_nxt.x = s_r.x + `NBDT_ONE16;
                  end
                  if ((OP_IN.src == LOC_MYI) || (OP_IN.dst == LOC_MYI)) begin
                     s_nxt.y = s_r.y + `NBDT_ONE16;
                  end
               end
            end else if (REG_REQ.wr) begin
               case (REG_REQ.addr)
                  `NBDT_REG_A: s_nxt.a = REG_REQ.wdata[3:0];
                  `NBDT_REG_B: s_nxt.b = REG_REQ.wdata[3:0];
                  `NBDT_REG_X: s_nxt.x = REG_REQ.wdata;
                  `NBDT_REG_Y: s_nxt.y = REG_REQ.wdata;
                  `NBDT_REG_F: s_nxt.f = REG_REQ.wdata[3:0];
                  `NBDT_REG_EXT: s_nxt.ext = REG_REQ.wdata[7:0];
                  `NBDT_REG_SP1: s_nxt.sp1 = {6'h00, REG_REQ.wdata[7:0], 2'h0};
                  `NBDT_REG_SP2: s_nxt.sp2 = {8'h00, REG_REQ.wdata[7:0]};
                  `NBDT_REG_PC: s_nxt.pc = REG_REQ.wdata;
                  default: s_nxt.pc = s_r.pc;
               endcase
            end
         end
         S_RUN1: begin
            // read strobe is out this cycle, data arrives next cycle
            s_nxt.st = S_WB;
         end
         S_WB: begin
            s_nxt.st = S_IDLE;
            s_nxt.done = 1'b1;
            case (s_r.op.dst)
               LOC_A: s_nxt.a = MEM_RDATA;
               LOC_B: s_nxt.b = MEM_RDATA;
               LOC_F: s_nxt.f = MEM_RDATA;
               default: begin
                  s_nxt.mem.wr = 1'b1;
                  s_nxt.mem.addr = s_r.daddr;
                  s_nxt.mem.wdata = MEM_RDATA;
               end
            endcase
         end
         default: s_nxt.st = S_IDLE;
      endcase
      s_nxt.rdata = `NBDT_RST16;
      if (REG_REQ.rd) begin
         case (REG_REQ.addr)
            `NBDT_REG_A: s_nxt.rdata = {12'h000, s_r.a};
            `NBDT_REG_B: s_nxt.rdata = {12'h000, s_r.b};
            `NBDT_REG_X: s_nxt.rdata = s_r.x;
            `NBDT_REG_Y: s_nxt.rdata = s_r.y;
            `NBDT_REG_F: s_nxt.rdata = {12'h000, s_r.f};
            `NBDT_REG_EXT: s_nxt.rdata = {8'h00, s_r.ext};
            `NBDT_REG_SP1: s_nxt.rdata = s_r.sp1;
            `NBDT_REG_SP2: s_nxt.rdata = s_r.sp2;
            `NBDT_REG_PC: s_nxt.rdata = s_r.pc;
            default: s_nxt.rdata = `NBDT_RST16;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign OP_READY = (s_r.st == S_IDLE);
   assign OP_DONE = s_r.done;
   assign MEM_OUT = s_r.mem;
   assign REG_RDATA = s_r.rdata;
endmodule : nbdt_core

// File: nbdt_mem_model.sv
// behavioural data memory on the far side of the core bus
module nbdt_mem_model (
   input wire logic clk,
   input nbdt_pkg::nbdt_mem_s mem_out,
   output logic [3:0] rdata
);
   import nbdt_pkg::*;
   logic [3:0] mem [0:65535];
   initial rdata = 4'h0;
   // read data stands one cycle only, then turns over
   always @(posedge clk) begin
      if (mem_out.wr) begin
         mem[mem_out.addr] <= mem_out.wdata;
      end
      if (mem_out.rd) begin
         rdata <= mem[mem_out.addr];
      end else begin
         rdata <= ~rdata;
      end
   end
endmodule : nbdt_mem_model

// File: nbdt_core_props.sv
// property checker for the nibble core data transfer block
module nbdt_core_props (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic OP_VALID,
   input nbdt_pkg::nbdt_op_s OP_IN,
   input wire logic OP_READY,
   input wire logic OP_DONE,
   input nbdt_pkg::nbdt_mem_s MEM_OUT,
   input wire logic [3:0] MEM_RDATA,
   input nbdt_pkg::nbdt_reg_req_s REG_REQ,
   input wire logic [15:0] REG_RDATA
);
   import nbdt_pkg::*;
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   wire logic take = OP_VALID && OP_READY;
   sequence s_src(nbdt_loc_e l);
      take && OP_IN.kind == NK_MOVE && OP_IN.src == l;
   endsequence
   sequence s_rd(logic [3:0] a);
      REG_REQ.rd && REG_REQ.addr == a;
   endsequence
   a_rd_then_done: assert property (MEM_OUT.rd |-> ##2 OP_DONE)
      else $error("memory read not finished two cycles later");
   a_wr_with_done: assert property (MEM_OUT.wr |-> OP_DONE)
      else $error("memory write outside the finishing cycle");
   a_ready_done: assert property (take |=> OP_READY == OP_DONE)
      else $error("ready and done disagree after taking an op");
   a_low_byte: assert property (s_src(LOC_L8) |=> MEM_OUT.rd && MEM_OUT.addr[15:8] == 8'h00)
      else $error("low page byte address wrong");
   a_high_byte: assert property (s_src(LOC_H8) |=> MEM_OUT.rd && MEM_OUT.addr[15:8] == 8'hFF)
      else $error("high page byte address wrong");
   a_low_six: assert property (s_src(LOC_L6) |=> MEM_OUT.rd && MEM_OUT.addr[15:6] == 10'h000)
      else $error("low page six bit address wrong");
   a_high_six: assert property (s_src(LOC_H6) |=> MEM_OUT.rd && MEM_OUT.addr[15:6] == 10'h3FF)
      else $error("high page six bit address wrong");
   a_wide_sp: assert property (s_rd(4'h6) |=> REG_RDATA[15:10] == 6'h00 && REG_RDATA[1:0] == 2'h0)
      else $error("wide stack pointer has stray bits");
   a_nibble_sp: assert property (s_rd(4'h7) |=> REG_RDATA[15:8] == 8'h00)
      else $error("nibble stack pointer has stray bits");
   a_flag_width: assert property (s_rd(4'h4) |=> REG_RDATA[15:4] == 12'h000)
      else $error("flag register wider than four bits");
endmodule : nbdt_core_props

// File: nbdt_core_bench.sv
// self-checking bench for the nibble core data transfer block
module nbdt_core_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import nbdt_pkg::*;
   logic CLK = 1'b0;
   logic NRST = 1'b0;
   logic OP_VALID = 1'b0;
   nbdt_op_s OP_IN = '0;
   nbdt_reg_req_s REG_REQ = '0;
   logic OP_READY, OP_DONE;
   nbdt_mem_s MEM_OUT;
   logic [3:0] MEM_RDATA;
   logic [15:0] REG_RDATA;
   int err_total = 0;
   int total_checks = 0;
   int n_ops = 0;
   nbdt_loc_e locs [4] = '{LOC_L6, LOC_H6, LOC_L8, LOC_H8};
   nbdt_iw_e ws [4] = '{IW6, IW6, IW8, IW8};
   logic [15:0] adrs [4] = '{16'h0015, 16'hFFD5, 16'h0095, 16'hFF95};
   always #5 CLK = ~CLK;
   nbdt_core DUT (.CLK(CLK), .NRST(NRST), .OP_VALID(OP_VALID), .OP_IN(OP_IN),
      .OP_READY(OP_READY), .OP_DONE(OP_DONE), .MEM_OUT(MEM_OUT), .MEM_RDATA(MEM_RDATA),
      .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA));
   nbdt_mem_model mem_i (.clk(CLK), .mem_out(MEM_OUT), .rdata(MEM_RDATA));
   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test
   task automatic reg_wr(logic [3:0] a, logic [15:0] d);
      @(posedge CLK);
      REG_REQ <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge CLK);
      REG_REQ <= '0;
   endtask : reg_wr
   task automatic reg_rd(logic [3:0] a, logic [15:0] e);
      @(posedge CLK);
      REG_REQ <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge CLK);
      REG_REQ <= '0;
      #1 check($sformatf("reg %0d", a), e, REG_RDATA);
   endtask : reg_rd
   task automatic run_op(nbdt_kind_e k, nbdt_loc_e d, nbdt_loc_e s, nbdt_bdst_e b,
      nbdt_iw_e w, logic g, logic [7:0] i);
      int n;
      @(posedge CLK);
      OP_VALID <= 1'b1;
      OP_IN <= '{k, d, s, b, w, g, i};
      @(posedge CLK);
      OP_VALID <= 1'b0;
      n_ops++;
      #1;
      for (n = 0; n < 8 && OP_DONE !== 1'b1; n++) @(posedge CLK) #1;
      check("done", 16'h0001, {15'h0000, OP_DONE});
      @(posedge CLK);
      #1;
   endtask : run_op
   task automatic mv(nbdt_loc_e d, nbdt_loc_e s, nbdt_iw_e w, logic [7:0] i);
      run_op(NK_MOVE, d, s, BD_BA, w, 1'b0, i);
   endtask : mv
   task automatic by(nbdt_bdst_e b, logic g, logic [7:0] i);
      run_op(NK_BYTE, LOC_A, LOC_A, b, IW8, g, i);
   endtask : by
   initial begin
      #100000;
      err_total++;
      stop_test();
   end
   initial begin
      repeat (3) @(posedge CLK);
      NRST <= 1'b1;
      for (int r = 0; r < 10; r++) reg_rd(4'(r), 16'h0000);
      by(BD_BA, 1'b0, 8'hA5);
      reg_rd(4'h0, 16'h0005);
      reg_rd(4'h1, 16'h000A);
      by(BD_X, 1'b1, 8'h80);
      reg_rd(4'h2, 16'hFF80);
      by(BD_XH, 1'b0, 8'h12);
      by(BD_XL, 1'b0, 8'h34);
      reg_rd(4'h2, 16'h1234);
      by(BD_YH, 1'b0, 8'hAB);
      by(BD_YL, 1'b0, 8'hCD);
      reg_rd(4'h3, 16'hABCD);
      mv(LOC_MYI, LOC_IMM, IW4, 8'hFC);
      check("mem", 16'h000C, mem_i.mem[16'hABCD]);
      reg_rd(4'h3, 16'hABCE);
      by(BD_SP1, 1'b0, 8'h81);
      reg_rd(4'h6, 16'h0204);
      by(BD_SP2, 1'b0, 8'hFE);
      reg_rd(4'h7, 16'h00FE);
      reg_wr(4'h6, 16'h00FF);
      reg_rd(4'h6, 16'h03FC);
      reg_wr(4'h7, 16'h01AB);
      reg_rd(4'h7, 16'h00AB);
      reg_wr(4'h9, 16'h1111);
      reg_rd(4'h9, 16'h0000);
      mv(LOC_MXI, LOC_A, IW4, 8'h00);
      check("mem", 16'h0005, mem_i.mem[16'h1234]);
      reg_rd(4'h2, 16'h1235);
      mem_i.mem[16'h1235] = 4'h9;
      by(BD_Y, 1'b0, 8'h40);
      mv(LOC_MY, LOC_MXI, IW4, 8'h00);
      check("mem", 16'h0009, mem_i.mem[16'h0040]);
      reg_rd(4'h2, 16'h1236);
      by(BD_EXT, 1'b0, 8'h77);
      reg_rd(4'h4, 16'h0008);
      mv(LOC_MY, LOC_A, IW4, 8'h00);
      check("mem", 16'h0005, mem_i.mem[16'hFF77]);
      reg_rd(4'h4, 16'h0000);
      mv(LOC_MY, LOC_B, IW4, 8'h00);
      check("mem", 16'h000A, mem_i.mem[16'h0040]);
      mem_i.mem[16'h0021] = 4'h6;
      by(BD_EXT, 1'b0, 8'h21);
      mv(LOC_A, LOC_MX, IW4, 8'h00);
      reg_rd(4'h0, 16'h0006);
      for (int k = 0; k < 4; k++) begin
         mv(locs[k], LOC_B, ws[k], 8'h95);
         check("abs", 16'h000A, mem_i.mem[adrs[k]]);
         mv(LOC_A, LOC_IMM, IW2, 8'hFF);
         reg_rd(4'h0, 16'h0003);
         mv(LOC_A, locs[k], ws[k], 8'h95);
         reg_rd(4'h0, 16'h000A);
      end
      mv(LOC_F, LOC_IMM, IW4, 8'h07);
      reg_rd(4'h4, 16'h0007);
      mv(LOC_A, LOC_F, IW4, 8'h00);
      reg_rd(4'h0, 16'h0007);
      mv(LOC_F, LOC_IMM, IW4, 8'h0F);
      mv(LOC_B, LOC_A, IW4, 8'h00);
      reg_rd(4'h4, 16'h0007);
      reg_rd(4'h8, 16'(n_ops));
      stop_test();
   end
endmodule : nbdt_core_bench
bind nbdt_core nbdt_core_props chk_i (.CLK(CLK), .NRST(NRST), .OP_VALID(OP_VALID),
   .OP_IN(OP_IN), .OP_READY(OP_READY), .OP_DONE(OP_DONE), .MEM_OUT(MEM_OUT),
   .MEM_RDATA(MEM_RDATA), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA));
